// File: common/spcl_consts.svh
// Offsets, field positions and reset values of the port config word loader
`ifndef SPCL_CONSTS_SVH
`define SPCL_CONSTS_SVH

// Image word addresses, in load order
`define SPCL_W_PM_DATA_P1   8'h53
`define SPCL_W_PM_CAP_P2    8'h54
`define SPCL_W_PM_DATA_P2   8'h55
`define SPCL_W_SLOT_P0      8'h60
`define SPCL_W_SLOT_P1      8'h62
`define SPCL_W_SLOT_P2      8'h64
`define SPCL_NUM_WORDS      3'd6

// Configuration dword offsets within one port
`define SPCL_OFF_PM_CAP     10'h040
`define SPCL_OFF_PM_CSR     10'h044
`define SPCL_OFF_PCIE_CAP   10'h0C0
`define SPCL_OFF_PORT_NUM   10'h0CC
`define SPCL_OFF_SLOT_CLK   10'h0D0
`define SPCL_OFF_LPVC       10'h144
`define SPCL_OFF_TC_MAP     10'h154

// Loader registers, in port slot 3
`define SPCL_PORT_LOADER    2'd3
`define SPCL_OFF_CTRL       10'h000
`define SPCL_OFF_STATUS     10'h004
`define SPCL_CTRL_RELOAD    0
`define SPCL_STAT_READY     0
`define SPCL_STAT_BUSY      1

// Image word bit positions
`define SPCL_IB_NO_SRST     0
`define SPCL_IB_AUX_LO      1
`define SPCL_IB_D1_SUP      4
`define SPCL_IB_D2_SUP      5
`define SPCL_IB_PME_LO      6
`define SPCL_IB_PM_DATA_LO  8
`define SPCL_IB_SLOT_IMPL   0
`define SPCL_IB_SLOT_CLK    1
`define SPCL_IB_DSI         2
`define SPCL_IB_LPVC        3
`define SPCL_IB_PNUM_LO     4
`define SPCL_IB_TC_LO       9

// Config dword bit positions
`define SPCL_CB_NO_SRST     3
`define SPCL_CB_DSI         21
`define SPCL_CB_AUX_LO      22
`define SPCL_CB_D1_SUP      25
`define SPCL_CB_D2_SUP      26
`define SPCL_CB_PME_LO      28
`define SPCL_CB_PM_DATA_LO  24
`define SPCL_CB_SLOT_IMPL   24
`define SPCL_CB_PNUM_LO     24
`define SPCL_CB_SLOT_CLK    28
`define SPCL_CB_LPVC        4
`define SPCL_CB_TC_LO       1

`define SPCL_RST_DWORD      32'h0000_0000

`endif

// File: common/spcl_pkg.sv
// Types of the port config word loader
package spcl_pkg;

    typedef struct packed {
        logic [7:0] pm_data;
        logic       no_soft_rst;
        logic [2:0] aux_cur;
        logic       d1_sup;
        logic       d2_sup;
        logic [1:0] pme_d2d1;
        logic       slot_impl;
        logic       slot_clk;
        logic       dsi_req;
        logic       lpvc_vc1;
        logic [2:0] port_num;
        logic [6:0] tc_map;
    } spcl_port_fld_t;

    typedef enum logic [1:0] {
        SPCL_ST_REQ  = 2'b00,
        SPCL_ST_WAIT = 2'b01,
        SPCL_ST_DONE = 2'b10
    } spcl_state_t;

endpackage : spcl_pkg

// File: common/spcl_word_if.sv
// Word fetch carrier between loader core and image reader
`timescale 1ns/1ps
`default_nettype none
interface spcl_word_if;
    logic        req;
    logic [7:0]  addr;
    logic        done;
    logic [15:0] data;

    modport loader (output req, addr, input done, data);
    modport reader (input req, addr, output done, data);
endinterface : spcl_word_if
`default_nettype wire

// File: core/spcl_img_reader.sv
// Fetches one image word from external storage per request
`timescale 1ns/1ps
`default_nettype none
module spcl_img_reader (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Loader side
    spcl_word_if.reader      wif,
    // Image storage side
    output var  logic        img_rd_r,
    output var  logic [7:0]  img_addr_r,
    input  wire logic [15:0] img_data,
    input  wire logic        img_valid
);
    logic        busy_r,   busy_nxt;
    logic        rd_nxt;
    logic [7:0]  addr_nxt;
    logic        done_r,   done_nxt;
    logic [15:0] data_r,   data_nxt;

    always_comb begin
        busy_nxt = busy_r;
        rd_nxt   = 1'b0;
        addr_nxt = img_addr_r;
        done_nxt = 1'b0;
        data_nxt = data_r;
        if (!busy_r && wif.req) begin
            busy_nxt = 1'b1;
            rd_nxt   = 1'b1;
            addr_nxt = wif.addr;
        end else if (busy_r && img_valid) begin
            // Valid during the read pulse itself is ignored
            if (!img_rd_r) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                data_nxt = img_data;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            busy_r     <= 1'b0;
            img_rd_r   <= 1'b0;
            img_addr_r <= 8'h00;
            done_r     <= 1'b0;
            data_r     <= 16'h0000;
        end else begin
            busy_r     <= busy_nxt;
            img_rd_r   <= rd_nxt;
            img_addr_r <= addr_nxt;
            done_r     <= done_nxt;
            data_r     <= data_nxt;
        end
    end

    assign wif.done = done_r;
    assign wif.data = data_r;
endmodule : spcl_img_reader
`default_nettype wire

// File: core/spcl_loader.sv
// Loads per-port configuration fields from image words 53h to 64h
// Operation
// - Word 53h upper byte loads port 1 PM data, offset 44h bits 31:24.
// - Word 54h bit 0 loads port 2 no-soft-reset flag, 44h bit 3.
// - Word 54h bits 3:1 load port 2 aux current, 40h bits 24:22.
// - Capability word bits 4,5 drive D1/D2 support bits 25,26 at 40h.
// - Capability word bits 7:6 load PME D2/D1 support, 40h bits 29:28.
// - Word 55h upper byte loads port 2 PM data, 44h bits 31:24.
// - Word 60h bit 1 loads port 0 slot clock, D0h bit 28.
// - Word 60h bit 2 loads port 0 init-required, 40h bit 21.
// - Word 60h bit 3 puts VC1 in port 0 low-priority group, 144h bit 4.
// - Word 60h bits 6:4 give port 0 logical number, CCh bits 26:24.
// - Word 60h bits 15:9 load port 0 TC map, 154h bits 7:1.
// - Word 62h bit 0 marks port 1 slot implemented, C0h bit 24.
// - Word 62h loads port 1 fields with word 60h layout.
// - Word 64h bits 0,1 load port 2 slot implemented and slot clock.
`timescale 1ns/1ps
`default_nettype none
`include "spcl_consts.svh"
module spcl_loader
    import spcl_pkg::*;
#(
    parameter int NUM_PORTS = 3
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Image storage
    output var  logic        img_rd_r,
    output var  logic [7:0]  img_addr_r,
    input  wire logic [15:0] img_data,
    input  wire logic        img_valid,
    // Register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [31:0] reg_rdata_r,
    // Status
    output var  logic        cfg_ready_r
);
    spcl_word_if wif ();

    spcl_state_t    state_r, state_nxt;
    logic [2:0]     idx_r,   idx_nxt;
    logic           ready_nxt;
    logic           req_r,   req_nxt;
    logic [31:0]    rdata_nxt;
    spcl_port_fld_t fld_r   [NUM_PORTS];
    spcl_port_fld_t fld_nxt [NUM_PORTS];

    // Image word address of each load step
    function automatic logic [7:0] word_addr(input logic [2:0] i);
        unique case (i)
            3'd0:    word_addr = `SPCL_W_PM_DATA_P1;
            3'd1:    word_addr = `SPCL_W_PM_CAP_P2;
            3'd2:    word_addr = `SPCL_W_PM_DATA_P2;
            3'd3:    word_addr = `SPCL_W_SLOT_P0;
            3'd4:    word_addr = `SPCL_W_SLOT_P1;
            default: word_addr = `SPCL_W_SLOT_P2;
        endcase
    endfunction : word_addr

    // PM capability layout of a port
    function automatic spcl_port_fld_t apply_pm_cap(
        input spcl_port_fld_t f,
        input logic [15:0]    w
    );
        spcl_port_fld_t r;
        r             = f;
        r.no_soft_rst = w[`SPCL_IB_NO_SRST];
        r.aux_cur     = w[`SPCL_IB_AUX_LO +: 3];
        r.d1_sup      = w[`SPCL_IB_D1_SUP];
        r.d2_sup      = w[`SPCL_IB_D2_SUP];
        r.pme_d2d1    = w[`SPCL_IB_PME_LO +: 2];
        return r;
    endfunction : apply_pm_cap

    // Slot word layout, shared by ports 0, 1 and 2
    function automatic spcl_port_fld_t apply_slot(
        input spcl_port_fld_t f,
        input logic [15:0]    w,
        input logic           has_impl
    );
        spcl_port_fld_t r;
        r          = f;
        if (has_impl) begin
            r.slot_impl = w[`SPCL_IB_SLOT_IMPL];
        end
        r.slot_clk = w[`SPCL_IB_SLOT_CLK];
        r.dsi_req  = w[`SPCL_IB_DSI];
        r.lpvc_vc1 = w[`SPCL_IB_LPVC];
        r.port_num = w[`SPCL_IB_PNUM_LO +: 3];
        r.tc_map   = w[`SPCL_IB_TC_LO +: 7];
        return r;
    endfunction : apply_slot

    // Config dword view of one port's fields
    function automatic logic [31:0] cfg_dword(
        input spcl_port_fld_t f,
        input logic [9:0]     off
    );
        logic [31:0] d;
        d = `SPCL_RST_DWORD;
        unique case (off)
            `SPCL_OFF_PM_CAP: begin
                d[`SPCL_CB_DSI]          = f.dsi_req;
                d[`SPCL_CB_AUX_LO +: 3]  = f.aux_cur;
                d[`SPCL_CB_D1_SUP]       = f.d1_sup;
                d[`SPCL_CB_D2_SUP]       = f.d2_sup;
                d[`SPCL_CB_PME_LO +: 2]  = f.pme_d2d1;
            end
            `SPCL_OFF_PM_CSR: begin
                d[`SPCL_CB_NO_SRST]          = f.no_soft_rst;
                d[`SPCL_CB_PM_DATA_LO +: 8]  = f.pm_data;
            end
            `SPCL_OFF_PCIE_CAP: d[`SPCL_CB_SLOT_IMPL]   = f.slot_impl;
            `SPCL_OFF_PORT_NUM: d[`SPCL_CB_PNUM_LO +: 3] = f.port_num;
            `SPCL_OFF_SLOT_CLK: d[`SPCL_CB_SLOT_CLK]    = f.slot_clk;
            `SPCL_OFF_LPVC:     d[`SPCL_CB_LPVC]        = f.lpvc_vc1;
            `SPCL_OFF_TC_MAP:   d[`SPCL_CB_TC_LO +: 7]  = f.tc_map;
            default:            d = `SPCL_RST_DWORD;
        endcase
        return d;
    endfunction : cfg_dword

    // Load sequencer
    always_comb begin
        state_nxt = state_r;
        idx_nxt   = idx_r;
        ready_nxt = cfg_ready_r;
        req_nxt   = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            fld_nxt[p] = fld_r[p];
        end
        unique case (state_r)
            SPCL_ST_REQ: begin
                req_nxt   = 1'b1;
                state_nxt = SPCL_ST_WAIT;
            end
            SPCL_ST_WAIT: begin
                if (wif.done) begin
                    unique case (idx_r)
                        3'd0: fld_nxt[1].pm_data =
                            wif.data[`SPCL_IB_PM_DATA_LO +: 8];
                        3'd1: fld_nxt[2] =
                            apply_pm_cap(fld_r[2], wif.data);
                        3'd2: fld_nxt[2].pm_data =
                            wif.data[`SPCL_IB_PM_DATA_LO +: 8];
                        3'd3: fld_nxt[0] =
                            apply_slot(fld_r[0], wif.data, 1'b0);
                        3'd4: fld_nxt[1] =
                            apply_slot(fld_r[1], wif.data, 1'b1);
                        default: fld_nxt[2] =
                            apply_slot(fld_r[2], wif.data, 1'b1);
                    endcase
                    if (idx_r == `SPCL_NUM_WORDS - 3'd1) begin
                        state_nxt = SPCL_ST_DONE;
                        ready_nxt = 1'b1;
                    end else begin
                        idx_nxt   = idx_r + 3'd1;
                        state_nxt = SPCL_ST_REQ;
                    end
                end
            end
            SPCL_ST_DONE: begin
                if (reg_wr && reg_addr[11:10] == `SPCL_PORT_LOADER
                    && reg_addr[9:0] == `SPCL_OFF_CTRL
                    && reg_wdata[`SPCL_CTRL_RELOAD]) begin
                    // Reload closes config access until it completes
                    ready_nxt = 1'b0;
                    idx_nxt   = 3'd0;
                    state_nxt = SPCL_ST_REQ;
                end
            end
            default: begin
                state_nxt = SPCL_ST_REQ;
                idx_nxt   = 3'd0;
                ready_nxt = 1'b0;
            end
        endcase
    end

    // Register read path, one cycle after the strobe
    always_comb begin
        rdata_nxt = `SPCL_RST_DWORD;
        if (reg_rd) begin
            if (reg_addr[11:10] == `SPCL_PORT_LOADER) begin
                if (reg_addr[9:0] == `SPCL_OFF_STATUS) begin
                    rdata_nxt[`SPCL_STAT_READY] = cfg_ready_r;
                    rdata_nxt[`SPCL_STAT_BUSY]  = !cfg_ready_r;
                end
            end else if (cfg_ready_r) begin
                // Config space reads zero until the load is complete
                rdata_nxt = cfg_dword(fld_r[reg_addr[11:10]],
                                      reg_addr[9:0]);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r     <= SPCL_ST_REQ;
            idx_r       <= 3'd0;
            cfg_ready_r <= 1'b0;
            req_r       <= 1'b0;
            reg_rdata_r <= `SPCL_RST_DWORD;
        end else begin
            state_r     <= state_nxt;
            idx_r       <= idx_nxt;
            cfg_ready_r <= ready_nxt;
            req_r       <= req_nxt;
            reg_rdata_r <= rdata_nxt;
        end
    end

    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    fld_r[p] <= '0;
                end else begin
                    fld_r[p] <= fld_nxt[p];
                end
            end
        end
    endgenerate

    assign wif.req  = req_r;
    assign wif.addr = word_addr(idx_r);

    spcl_img_reader u_reader (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .wif        (wif),
        .img_rd_r   (img_rd_r),
        .img_addr_r (img_addr_r),
        .img_data   (img_data),
        .img_valid  (img_valid)
    );
endmodule : spcl_loader
`default_nettype wire

// File: test/spcl_loader_props.sv
// Port-level properties of the port config word loader
`timescale 1ns/1ps
`default_nettype none
module spcl_loader_props (
    // Clock and reset
    input wire logic        clock,
    input wire logic        sys_rst,
    // Image storage
    input wire logic        img_rd_r,
    input wire logic [7:0]  img_addr_r,
    input wire logic [15:0] img_data,
    input wire logic        img_valid,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_r,
    // Status
    input wire logic        cfg_ready_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire logic cfg_sel = reg_addr[11:10] != 2'd3;

    property p_first_fetch;
        $fell(sys_rst) |-> ##[1:3] (img_rd_r && img_addr_r == 8'h53);
    endproperty
    a_first_fetch: assert property (p_first_fetch)
        else $error("first fetch not to word 53h");
    property p_rd_pulse; img_rd_r |=> !img_rd_r; endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("fetch request longer than one cycle");
    property p_addr_hold; !img_rd_r |-> $stable(img_addr_r); endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("fetch address moved without request");
    // Word taken, field loaded, request, then pulse: four sampled edges
    property p_next_fetch;
        img_valid && img_addr_r != 8'h64 |-> ##4 img_rd_r;
    endproperty
    a_next_fetch: assert property (p_next_fetch)
        else $error("next fetch not four cycles after word");
    property p_ready_last;
        img_valid && img_addr_r == 8'h64 |-> ##2 cfg_ready_r;
    endproperty
    a_ready_last: assert property (p_ready_last)
        else $error("ready not two cycles after last word");
    property p_no_fetch; cfg_ready_r |-> !img_rd_r; endproperty
    a_no_fetch: assert property (p_no_fetch)
        else $error("fetch while ready");
    property p_rdata_idle; !reg_rd |=> reg_rdata_r == 32'h0000_0000; endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data without read");
    property p_closed;
        reg_rd && !cfg_ready_r && cfg_sel |=> reg_rdata_r == 32'h0000_0000;
    endproperty
    a_closed: assert property (p_closed)
        else $error("config read open before load done");
    property p_pm_cap;
        reg_rd && cfg_sel && reg_addr[9:0] == 10'h040
            |=> (reg_rdata_r & 32'hC01F_FFFF) == 32'h0000_0000;
    endproperty
    a_pm_cap: assert property (p_pm_cap)
        else $error("stray bits in capability dword");
endmodule : spcl_loader_props
`default_nettype wire

// File: test/spcl_img_model.sv
// Behavioural image storage answering word fetches
`timescale 1ns/1ps
`default_nettype none
module spcl_img_model (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // Fetch side
    input  wire logic             img_rd_r,
    input  wire logic [7:0]       img_addr_r,
    output var  logic [15:0]      img_data,
    output var  logic             img_valid,
    // Content of words 53h,54h,55h,60h,62h,64h and answer delay
    input  wire logic [5:0][15:0] words,
    input  wire logic [3:0]       lat
);
    logic       pend;
    logic [3:0] cnt;
    wire logic [2:0] idx = img_addr_r[5] ? 3'd3 + {1'b0, img_addr_r[2:1]}
                                         : img_addr_r[2:0] - 3'd3;
    always @(posedge clock) begin
        if (sys_rst) begin
            pend      <= 1'b0;
            cnt       <= 4'h0;
            img_valid <= 1'b0;
            img_data  <= 16'h0000;
        end else begin
            img_valid <= 1'b0;
            // Stale word inverted so a late capture cannot pass
            if (img_valid)
                img_data <= ~img_data;
            if (img_rd_r) begin
                pend <= 1'b1;
                cnt  <= lat;
            end else if (pend && cnt == 4'h0) begin
                pend      <= 1'b0;
                img_valid <= 1'b1;
                img_data  <= words[idx];
            end else if (pend)
                cnt <= cnt - 4'h1;
        end
    end
endmodule : spcl_img_model
`default_nettype wire

// File: test/spcl_loader_tb.sv
// Self-checking bench of the port config word loader
`timescale 1ns/1ps
`default_nettype none
module spcl_loader_tb;
    logic             clock, sys_rst, reg_wr, reg_rd, cfg_ready_r;
    logic             img_rd_r, img_valid;
    logic [7:0]       img_addr_r;
    logic [15:0]      img_data;
    logic [11:0]      reg_addr;
    logic [31:0]      reg_wdata, reg_rdata_r, d;
    logic [5:0][15:0] words;
    logic [3:0]       lat;
    int               n_mismatch, num_checks;

    spcl_loader dut (.clock(clock), .sys_rst(sys_rst),
        .img_rd_r(img_rd_r), .img_addr_r(img_addr_r),
        .img_data(img_data), .img_valid(img_valid), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r), .cfg_ready_r(cfg_ready_r));
    spcl_img_model u_img (.clock(clock), .sys_rst(sys_rst),
        .img_rd_r(img_rd_r), .img_addr_r(img_addr_r), .img_data(img_data),
        .img_valid(img_valid), .words(words), .lat(lat));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_r;
        check(d, exp);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic wait_ready();
        for (int i = 0; i < 300 && cfg_ready_r !== 1'b1; i++)
            @(posedge clock);
        if (cfg_ready_r !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask : wait_ready
    function automatic logic [31:0] exp_dw(input int p, input logic [9:0] o);
        logic [15:0] s, w, m;
        s = words[3 + p];
        w = (p == 2) ? words[1] : 16'h0000;
        m = (p == 1) ? words[0] : (p == 2) ? words[2] : 16'h0000;
        case (o)
            10'h040: exp_dw = {4'(w[7:6]), 1'b0, w[5:1], s[2], 21'h0};
            10'h044: exp_dw = {m[15:8], 20'h0, w[0], 3'h0};
            10'h0C0: exp_dw = {7'h0, (p != 0) && s[0], 24'h0};
            10'h0CC: exp_dw = {5'h0, s[6:4], 24'h0};
            10'h0D0: exp_dw = {3'h0, s[1], 28'h0};
            10'h144: exp_dw = {27'h0, s[3], 4'h0};
            10'h154: exp_dw = {24'h0, s[15:9], 1'b0};
            default: exp_dw = 32'h0000_0000;
        endcase
    endfunction : exp_dw
    task automatic check_all();
        logic [9:0] offs [8] = '{10'h040, 10'h044, 10'h0C0, 10'h0CC,
                                 10'h0D0, 10'h144, 10'h154, 10'h048};
        for (int p = 0; p < 3; p++)
            foreach (offs[k])
                rd({2'(p), offs[k]}, exp_dw(p, offs[k]));
        rd(12'hC04, 32'h0000_0001);
    endtask : check_all
    task automatic t_boot();
        rd(12'h0CC, 32'h0000_0000);
        rd(12'hC04, 32'h0000_0002);
        wait_ready();
        check_all();
        $display("boot load test done");
    endtask : t_boot
    task automatic t_reload();
        words = ~words;
        lat   = 4'h9;
        wr(12'hC00, 32'h0000_0001);
        rd(12'hC04, 32'h0000_0002);
        rd(12'h444, 32'h0000_0000);
        wr(12'hC00, 32'h0000_0001);
        wait_ready();
        // Write to a read-only config dword must not stick
        wr(12'h0CC, 32'hFFFF_FFFF);
        check_all();
        check(32'(cfg_ready_r), 32'h0000_0001);
        $display("reload test done");
    endtask : t_reload
    task automatic t_reset();
        words = {16'h8001, 16'hFFFE, 16'h7F00, 16'h00FF, 16'hA5A5, 16'h5A5A};
        lat   = 4'h3;
        wr(12'hC00, 32'h0000_0001);
        repeat (12) @(posedge clock);
        sys_rst <= 1'b1;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        rd(12'h844, 32'h0000_0000);
        wait_ready();
        check_all();
        $display("mid-load reset test done");
    endtask : t_reset

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        sys_rst   = 1'b1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 12'h000;
        reg_wdata = 32'h0000_0000;
        lat       = 4'h0;
        words = {16'h1357, 16'h2468, 16'hFFFF, 16'h0000, 16'hC3A5, 16'h5AF0};
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        t_boot();
        t_reload();
        t_reset();
        tally_and_finish();
    end
endmodule : spcl_loader_tb
bind spcl_loader spcl_loader_props u_props (.clock(clock),
    .sys_rst(sys_rst), .img_rd_r(img_rd_r), .img_addr_r(img_addr_r),
    .img_data(img_data), .img_valid(img_valid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .cfg_ready_r(cfg_ready_r));
`default_nettype wire
